//--- verilog/pbd_consts.vh
// Constants for the port B/C/D function select block
`ifndef PBD_CONSTS_VH
`define PBD_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define PBD_ADDR_W 3
`define PBD_OFS_PB_LOW 3'h0
`define PBD_OFS_PB_HIGH 3'h1
`define PBD_OFS_PC_LOW 3'h2
`define PBD_OFS_PC_HIGH 3'h3
`define PBD_OFS_PD 3'h4
`define PBD_OFS_IN_SRC 3'h5

// ****************************************
// Reset values and implemented bits
// ****************************************
`define PBD_RST_VAL 8'h00
`define PBD_PD_MASK 8'h0f
`define PBD_IN_SRC_MASK 8'h7f

// ****************************************
// Function codes of a pin field
// ****************************************
`define PBD_CODE_GPIO 2'h0
`define PBD_CODE_SEG 2'h1
`define PBD_CODE_ALT2 2'h2
`define PBD_CODE_ALT3 2'h3

// ****************************************
// Pin indices in the pad vector
// ****************************************
`define PBD_NPINS 18
`define PBD_PB0 0
`define PBD_PB6 6
`define PBD_PORT_B_LINE_7 7
`define PBD_PC0 8
`define PBD_PC1 9
`define PBD_PC2 10
`define PBD_PORT_C_LINE_3 11
`define PBD_PC4 12
`define PBD_PC5 13
`define PBD_PC6 14
`define PBD_PC7 15
`define PBD_PORT_D_LINE_0 16
`define PBD_PD1 17
`define PBD_NKEYS 16

// ****************************************
// Input source select fields
// ****************************************
`define PBD_SRC_SDA 6
`define PBD_SRC_SCL 5
`define PBD_SRC_RX 4
`define PBD_SRC_PTCK_HI 3
`define PBD_SRC_PTCK_LO 2
`define PBD_SRC_CTCK_HI 1
`define PBD_SRC_CTCK_LO 0

// Port A pin indices used as alternate sources
`define PBD_PA0 0
`define PBD_PA1 1
`define PBD_PA3 3
`define PBD_PA4 4
`define PBD_PA7 7

`endif

//--- verilog/pbd_pin_cell.v
// One pad: four-way output and enable selection, registered
`timescale 1ns/100ps
module pbd_pin_cell (
   // Clock and reset
   input wire clk_in,
   input wire nrst_in,
   // Function code
   input wire [1:0] code_in,
   // Candidate drives per code
   input wire [3:0] drv_out_in,
   input wire [3:0] drv_oe_in,
   // Pad drive
   output reg pad_out,
   output reg pad_oe_out
);

   always @(posedge clk_in) begin
      if (!nrst_in) begin
         pad_out <= 1'b0;
         pad_oe_out <= 1'b0;
      end else begin
         pad_out <= drv_out_in[code_in];
         pad_oe_out <= drv_oe_in[code_in];
      end
   end

endmodule // pbd_pin_cell

//--- verilog/pbd_func_select.v
// Pin function multiplexer and input source selection for ports B, C and D
`timescale 1ns/100ps
`include "pbd_consts.vh"
module pbd_func_select #(
   parameter NPINS = `PBD_NPINS,
   parameter NKEYS = `PBD_NKEYS
) (
   // Clock and reset
   input wire clk_in,
   input wire nrst_in,
   // Register port
   input wire [`PBD_ADDR_W-1:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [7:0] reg_rdata_out,
   // General I/O drive from port logic, per pad
   input wire [NPINS-1:0] gpio_out_in,
   input wire [NPINS-1:0] gpio_oe_in,
   // Segment/common driver, per pad
   input wire [NPINS-1:0] seg_out_in,
   input wire [NPINS-1:0] seg_oe_in,
   // Timer outputs
   input wire ctm0_out_in,
   input wire ctm1_out_in,
   input wire ptm0_out_in,
   // Serial peripheral drive
   input wire uart_tx_in,
   input wire uart_txrx_out_in,
   input wire uart_txrx_oe_in,
   input wire i2c_scl_low_in,
   input wire i2c_sda_low_in,
   // Pads
   input wire [NPINS-1:0] pad_in,
   output wire [NPINS-1:0] pad_out,
   output wire [NPINS-1:0] pad_oe_out,
   // Port A pad levels, alternate input sources
   input wire [7:0] porta_pad_in,
   // Routed peripheral inputs
   output reg [NKEYS-1:0] touch_key_out,
   output reg i2c_sda_out,
   output reg i2c_scl_out,
   output reg uart_rx_out,
   output reg ptm0_clock_out,
   output reg ctm0_clock_out,
   output reg ctm1_clock_out
);

   // ****************************************
   // Selection registers
   // ****************************************
   reg [7:0] pb_low_reg;
   reg [7:0] pb_high_reg;
   reg [7:0] pc_low_reg;
   reg [7:0] pc_high_reg;
   reg [7:0] pd_reg;
   reg [7:0] in_src_reg;
   reg [7:0] rdata_next;

   // Three-way pick with code 11 falling back to code 00
   function pick3;
      input [1:0] code;
      input src0;
      input src1;
      input src2;
      begin
         case (code)
            2'h1: pick3 = src1;
            2'h2: pick3 = src2;
            default: pick3 = src0;
         endcase
      end
   endfunction

   always @(posedge clk_in) begin
      if (!nrst_in) begin
         pb_low_reg <= `PBD_RST_VAL;
         pb_high_reg <= `PBD_RST_VAL;
         pc_low_reg <= `PBD_RST_VAL;
         pc_high_reg <= `PBD_RST_VAL;
         pd_reg <= `PBD_RST_VAL;
         in_src_reg <= `PBD_RST_VAL;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `PBD_OFS_PB_LOW: begin
               pb_low_reg <= reg_wdata_in;
            end
            `PBD_OFS_PB_HIGH: begin
               pb_high_reg <= reg_wdata_in;
            end
            `PBD_OFS_PC_LOW: begin
               pc_low_reg <= reg_wdata_in;
            end
            `PBD_OFS_PC_HIGH: begin
               pc_high_reg <= reg_wdata_in;
            end
            `PBD_OFS_PD: begin
               pd_reg <= reg_wdata_in & `PBD_PD_MASK;
            end
            `PBD_OFS_IN_SRC: begin
               in_src_reg <= reg_wdata_in & `PBD_IN_SRC_MASK;
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always @* begin
      rdata_next = 8'h00;
      case (reg_addr_in)
         `PBD_OFS_PB_LOW: rdata_next = pb_low_reg;
         `PBD_OFS_PB_HIGH: rdata_next = pb_high_reg;
         `PBD_OFS_PC_LOW: rdata_next = pc_low_reg;
         `PBD_OFS_PC_HIGH: rdata_next = pc_high_reg;
         `PBD_OFS_PD: rdata_next = pd_reg & `PBD_PD_MASK;
         `PBD_OFS_IN_SRC: rdata_next = in_src_reg & `PBD_IN_SRC_MASK;
         default: rdata_next = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rdata_next;
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   // ****************************************
   // Per-pad candidate drives
   // ****************************************
   wire [2*NPINS-1:0] codes;
   reg [NPINS-1:0] alt2_out;
   reg [NPINS-1:0] alt2_oe;
   reg [NPINS-1:0] alt3_out;
   reg [NPINS-1:0] alt3_oe;

   assign codes = {pd_reg[3:0], pc_high_reg, pc_low_reg, pb_high_reg, pb_low_reg};

   // Key mode leaves the pad undriven; the sense circuit only listens
   always @* begin
      alt2_out = {NPINS{1'b0}};
      alt2_oe = {NPINS{1'b0}};
      alt3_out = gpio_out_in;
      alt3_oe = gpio_oe_in;
      alt3_out[`PBD_PB6] = ~ctm0_out_in;
      alt3_oe[`PBD_PB6] = 1'b1;
      alt3_out[`PBD_PORT_B_LINE_7] = ctm0_out_in;
      alt3_oe[`PBD_PORT_B_LINE_7] = 1'b1;
      alt3_out[`PBD_PC0] = uart_txrx_out_in;
      alt3_oe[`PBD_PC0] = uart_txrx_oe_in;
      alt3_out[`PBD_PC1] = uart_tx_in;
      alt3_oe[`PBD_PC1] = 1'b1;
      // I2C lines are open drain: only ever pulled low
      alt3_out[`PBD_PC2] = 1'b0;
      alt3_oe[`PBD_PC2] = i2c_scl_low_in;
      alt3_out[`PBD_PORT_C_LINE_3] = 1'b0;
      alt3_oe[`PBD_PORT_C_LINE_3] = i2c_sda_low_in;
      alt3_out[`PBD_PC4] = ~ptm0_out_in;
      alt3_oe[`PBD_PC4] = 1'b1;
      alt3_out[`PBD_PC5] = ~ctm0_out_in;
      alt3_oe[`PBD_PC5] = 1'b1;
      alt3_out[`PBD_PC6] = ptm0_out_in;
      alt3_oe[`PBD_PC6] = 1'b1;
      alt3_out[`PBD_PC7] = ctm0_out_in;
      alt3_oe[`PBD_PC7] = 1'b1;
      alt2_out[`PBD_PORT_D_LINE_0] = ctm1_out_in;
      alt2_oe[`PBD_PORT_D_LINE_0] = 1'b1;
      alt2_out[`PBD_PD1] = ~ctm1_out_in;
      alt2_oe[`PBD_PD1] = 1'b1;
   end

   // ****************************************
   // Pad cells
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pad
         pbd_pin_cell u_cell (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .code_in(codes[2*gi+1:2*gi]),
            .drv_out_in({alt3_out[gi], alt2_out[gi], seg_out_in[gi], gpio_out_in[gi]}),
            .drv_oe_in({alt3_oe[gi], alt2_oe[gi], seg_oe_in[gi], gpio_oe_in[gi]}),
            .pad_out(pad_out[gi]),
            .pad_oe_out(pad_oe_out[gi])
         );
      end
   endgenerate

   // ****************************************
   // Routed inputs
   // ****************************************
   reg [NKEYS-1:0] key_next;
   integer ki;

   // Key line reads zero unless its pad is in key mode
   always @* begin
      key_next = {NKEYS{1'b0}};
      for (ki = 0; ki < NKEYS; ki = ki + 1) begin
         key_next[ki] = pad_in[ki] & (codes[2*ki+1 -: 2] == `PBD_CODE_ALT2);
      end
   end

   // Timer clock inputs share the GPIO code, so they are not gated by it;
   // the port must also be set as input by software
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         touch_key_out <= {NKEYS{1'b0}};
         i2c_sda_out <= 1'b0;
         i2c_scl_out <= 1'b0;
         uart_rx_out <= 1'b0;
         ptm0_clock_out <= 1'b0;
         ctm0_clock_out <= 1'b0;
         ctm1_clock_out <= 1'b0;
      end else begin
         touch_key_out <= key_next;
         i2c_sda_out <= in_src_reg[`PBD_SRC_SDA] ? pad_in[`PBD_PORT_C_LINE_3] :
            porta_pad_in[`PBD_PA3];
         i2c_scl_out <= in_src_reg[`PBD_SRC_SCL] ? pad_in[`PBD_PC2] :
            porta_pad_in[`PBD_PA7];
         uart_rx_out <= in_src_reg[`PBD_SRC_RX] ? pad_in[`PBD_PC0] :
            porta_pad_in[`PBD_PA3];
         ptm0_clock_out <= pick3(in_src_reg[`PBD_SRC_PTCK_HI:`PBD_SRC_PTCK_LO],
            porta_pad_in[`PBD_PA0], pad_in[`PBD_PC5], pad_in[`PBD_PC7]);
         ctm0_clock_out <= pick3(in_src_reg[`PBD_SRC_CTCK_HI:`PBD_SRC_CTCK_LO],
            porta_pad_in[`PBD_PA4], porta_pad_in[`PBD_PA1], pad_in[`PBD_PORT_B_LINE_7]);
         ctm1_clock_out <= pad_in[`PBD_PORT_D_LINE_0];
      end
   end

endmodule // pbd_func_select

//--- bench/pbd_pad_model.sv
// Pad model: level seen on each pin of ports B, C and D
`timescale 1ns/100ps
module pbd_pad_model (
   // Device drive
   input wire [17:0] pad_out_in,
   input wire [17:0] pad_oe_in,
   // Outside level on released pins
   input wire [17:0] ext_in,
   // Level back to the device
   output wire [17:0] lvl_out
);
   // Released pin takes the outside level, never the last driven value
   assign lvl_out = (pad_out_in & pad_oe_in) | (ext_in & ~pad_oe_in);
endmodule // pbd_pad_model

//--- bench/pbd_func_select_asserts.sv
// Checker for the port B/C/D function select block
`timescale 1ns/100ps
module pbd_func_select_asserts (
   // Clock and reset
   input wire clk_in,
   input wire nrst_in,
   // Register port
   input wire [2:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [7:0] reg_rdata_out,
   // Pads and routed inputs
   input wire [17:0] pad_in,
   input wire [17:0] pad_oe_out,
   input wire [15:0] touch_key_out,
   input wire ctm1_clock_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   property p_reset;
      disable iff (1'b0) !nrst_in |=> pad_oe_out == 18'h0 && touch_key_out == 16'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
   property p_rd_idle;
      !reg_rd_in |=> reg_rdata_out == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
   property p_pd_upper;
      $past(reg_rd_in) && $past(reg_addr_in) == 3'h4 |-> reg_rdata_out[7:4] == 4'h0;
   endproperty
   a_pd_upper: assert property (p_pd_upper) else $error("port D upper bits set");
   property p_src_top;
      $past(reg_rd_in) && $past(reg_addr_in) == 3'h5 |-> !reg_rdata_out[7];
   endproperty
   a_src_top: assert property (p_src_top) else $error("source bit 7 set");
   property p_readback;
      reg_rd_in && $past(reg_wr_in) && reg_addr_in == $past(reg_addr_in) && reg_addr_in < 3'h4
         |=> reg_rdata_out == $past(reg_wdata_in, 2);
   endproperty
   a_readback: assert property (p_readback) else $error("read after write stale");
   property p_ctm1_clk;
      $past(nrst_in) |-> ctm1_clock_out == $past(pad_in[16]);
   endproperty
   a_ctm1_clk: assert property (p_ctm1_clk) else $error("timer 1 clock not from pin");
   property p_key_b4;
      touch_key_out[4] |-> !pad_oe_out[4];
   endproperty
   a_key_b4: assert property (p_key_b4) else $error("key pin driven");
   property p_key_b0;
      touch_key_out[0] |-> !pad_oe_out[0];
   endproperty
   a_key_b0: assert property (p_key_b0) else $error("key pin driven");
endmodule // pbd_func_select_asserts
bind pbd_func_select pbd_func_select_asserts u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pad_in(pad_in),
   .pad_oe_out(pad_oe_out), .touch_key_out(touch_key_out), .ctm1_clock_out(ctm1_clock_out));

//--- bench/pbd_func_select_tb_top.sv
// Self-checking bench for the port B/C/D function select block
`timescale 1ns/100ps
module pbd_func_select_tb_top;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [2:0] reg_addr_in = 3'h0;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   // Bits: ctm0 ctm1 ptm0 tx txrx_out txrx_oe scl_low sda_low, from bit 0
   logic [7:0] drv = 8'h6b;
   logic [17:0] gv = 18'h15555, go = 18'h0007f, sv = 18'h2aaaa, so = 18'h3ffff;
   logic [7:0] porta = 8'h00;
   logic [17:0] ext = 18'h3ffff;
   wire [7:0] reg_rdata_out;
   wire [17:0] pad_out, pad_oe_out, pad_in;
   wire [15:0] touch_key_out;
   wire [5:0] routed;
   int fails = 0;
   int comparisons = 0;
   logic [7:0] ifs [4] = '{8'h00, 8'h75, 8'h0a, 8'h0f};
   logic [5:0] from_pa [4] = '{6'h3e, 6'h02, 6'h38, 6'h3e};
   logic [7:0] wv [7] = '{8'h55, 8'hfe, 8'hff, 8'hff, 8'hf6, 8'hff, 8'hff};
   logic [7:0] rv [7] = '{8'h55, 8'hfe, 8'hff, 8'hff, 8'h06, 8'h7f, 8'h00};
   pbd_func_select DUT (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .gpio_out_in(gv), .gpio_oe_in(go), .seg_out_in(sv),
      .seg_oe_in(so), .ctm0_out_in(drv[0]), .ctm1_out_in(drv[1]), .ptm0_out_in(drv[2]),
      .uart_tx_in(drv[3]), .uart_txrx_out_in(drv[4]), .uart_txrx_oe_in(drv[5]),
      .i2c_scl_low_in(drv[6]), .i2c_sda_low_in(drv[7]), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe_out(pad_oe_out), .porta_pad_in(porta), .touch_key_out(touch_key_out),
      .i2c_sda_out(routed[5]), .i2c_scl_out(routed[4]), .uart_rx_out(routed[3]),
      .ptm0_clock_out(routed[2]), .ctm0_clock_out(routed[1]), .ctm1_clock_out(routed[0]));
   pbd_pad_model u_pads (.pad_out_in(pad_out), .pad_oe_in(pad_oe_out), .ext_in(ext),
      .lvl_out(pad_in));
   initial begin
      forever #2 clk_in = ~clk_in;
   end
   task chk(input logic [17:0] g, input logic [17:0] e);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Called right after an edge; leaves right after the edge that took it
   task wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] e);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out, e);
   endtask
   task stop_test;
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1 chk(pad_out, gv);
      chk(pad_oe_out, go);
      for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(3'h5, ifs[i]);
         porta <= 8'hff;
         ext <= 18'h0;
         repeat (2) @(posedge clk_in);
         #1 chk(routed, from_pa[i]);
         porta <= 8'h00;
         ext <= 18'h3ffff;
         repeat (2) @(posedge clk_in);
         #1 chk(routed ^ 6'h3f, from_pa[i]);
      end
      // Selection first, timer levels change only afterwards
      for (int i = 0; i < 7; i++) begin
         wr(i[2:0], wv[i]);
         rd(i[2:0], rv[i]);
      end
      repeat (2) @(posedge clk_in);
      #1 chk(pad_out & 18'h3ffef, 18'h3928a);
      chk(pad_oe_out, 18'h3f7ef);
      chk(touch_key_out, 16'h0010);
      drv[0] <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1 chk(pad_out & 18'h3ffef, 18'h3324a);
      wr(3'h4, 8'h0f);
      wr(3'h0, 8'haa);
      repeat (2) @(posedge clk_in);
      #1 chk(pad_out & 18'h30000, 18'h10000);
      chk(touch_key_out, 16'h001f);
      chk(pad_oe_out & 18'h0001f, 18'h0);
      stop_test();
   end
endmodule // pbd_func_select_tb_top
